// ### rtl/fault_diag_consts.svh
// Constants for the fault lamp and diagnosis frame block
`ifndef FAULT_DIAG_CONSTS_SVH
`define FAULT_DIAG_CONSTS_SVH
`define CLK_HZ            50000000
`define BLINK_HZ          1
`define BLINK_HALF_CYCLES ((`CLK_HZ / `BLINK_HZ) / 2)
`define ADDR_MIN          8'h01
`define ADDR_MAX          8'h63
`define DIAG_STD_LEN      8'h06
`define DIAG_EXT_LEN      8'h09
`define DIAG_MAX_BYTES    241
`define DIAG_FRAME_LEN    8'h0f
`define EXT_STATUS_TYPE   8'h82
`define EXT_STATUS_ID     8'h00
`define MOD_STATUS_OK     8'h00
`define MOD_STATUS_CRC    8'h03
`define MAKER_ID_DEFAULT  16'h5a5a
`endif

// ### rtl/fault_diag_pkg.sv
// Types for the fault lamp and diagnosis frame block
package fault_diag_pkg;
  // Lamp indication, Gray ordered dark -> blink -> steady
  typedef enum logic [1:0]
  {
    LAMP_DARK   = 2'b00,
    LAMP_BLINK  = 2'b01,
    LAMP_STEADY = 2'b11
  } lamp_mode_type;
  // Frame readout sequencer
  typedef enum logic [1:0]
  {
    RD_IDLE = 2'b00,
    RD_SEND = 2'b01,
    RD_LAST = 2'b11
  } rd_state_type;
endpackage : fault_diag_pkg

// ### rtl/fault_diag_report.sv
// Fault lamp, latched fail-safe state and diagnosis frame readout
// Functional notes
// - Dark without error; blink 1 Hz on faults
// - Safety error forces fail-safe with substitute data
// - Fail-safe latched until power cycle only
// - Safety watchdog expiry counts as safety error
// - Window increments overrun counts as safety error
// - Address zero steady on; valid addresses 1..99
// - Defective computed safety telegram lights steady
// - Reconfigured-while-running reconnect lights steady
// - Bytes 1-3 station status; byte 4 master address
// - Bytes 5-6 maker identifier, high then low
// - Byte 7 extended length; frame ends by 241
// - Extended module status report always appended
// - Diagnosis exchange runs automatically, no user program
// - Module status 00 valid, 03 on checksum error
`timescale 1ns/1ps
`include "fault_diag_consts.svh"

module fault_diag_report
  import fault_diag_pkg::*;
#(
  parameter int          BLINK_HALF = `BLINK_HALF_CYCLES, // Cycles per lamp half period
  parameter logic [15:0] MAKER_ID   = `MAKER_ID_DEFAULT   // Arbitrary neutral value
)
(
  input  wire logic        clk_in,              // 50 MHz device clock
  input  wire logic        reset_in,            // Power-on reset, sync, active high
  input  wire logic        link_absent_in,      // No master link
  input  wire logic        addr_mismatch_in,    // Switch address differs from projected
  input  wire logic        param_crc_bad_in,    // indiv_param_checksum mismatch
  input  wire logic        safety_wd_expired_in,// safety_watchdog_time expired
  input  wire logic        safety_comm_err_in,  // Other safety communication error
  input  wire logic        window_exceed_in,    // Window increments exceeded
  input  wire logic        telegram_bad_in,     // Self-check: computed telegram defective
  input  wire logic        reconf_reconnect_in, // Reconnected after run-time reconfig
  input  wire logic [7:0]  addr_switch_in,      // Address switch value
  input  wire logic [31:0] live_data_in,        // Live position data
  input  wire logic [31:0] subst_data_in,       // Passivated substitute data
  input  wire logic [7:0]  station_stat1_in,    // Station status byte 1
  input  wire logic [7:0]  station_stat2_in,    // Station status byte 2
  input  wire logic [7:0]  station_stat3_in,    // Station status byte 3
  input  wire logic [7:0]  master_addr_in,      // Master station address
  input  wire logic [7:0]  slot_no_in,          // Slot number of module
  input  wire logic        diag_req_in,         // Pulse: start a frame readout
  output logic             red_lamp_out,        // Red lamp, high = lit
  output logic             fail_safe_out,       // Latched fail-safe state
  output logic             addr_valid_out,      // Address switch in 1..99
  output logic [31:0]      process_data_out,    // Data toward the bus
  output logic [7:0]       diag_byte_out,       // Frame byte
  output logic             diag_valid_out,      // Frame byte valid
  output logic             diag_last_out        // Last frame byte
);

  // Elaboration checks
  if (BLINK_HALF < 1)
  begin : g_bad_blink
    $error("BLINK_HALF must be at least one");
  end
  // The 26-bit half period counter cannot hold a longer half period
  if (BLINK_HALF > 67108864)
  begin : g_long_blink
    $error("BLINK_HALF exceeds the counter range");
  end
  if (`DIAG_FRAME_LEN > `DIAG_MAX_BYTES)
  begin : g_bad_len
    $error("Frame exceeds maximum length");
  end

  logic          fail_safe_q;     // Latched safety state
  logic          safety_err;      // Any safety-relevant error this cycle
  logic          steady_cond;     // Steady-on causes
  logic          blink_cond;      // Blink causes
  logic          addr_ok;         // Address in valid range
  logic [25:0]   blink_cnt_q;     // Half period counter
  logic          blink_ph_q;      // Blink phase
  lamp_mode_type lamp_mode;       // Resolved lamp mode
  rd_state_type  rd_state_q;      // Readout state
  logic [7:0]    rd_idx_q;        // Current byte index, 0 based
  logic [7:0]    frame_byte;      // Byte selected by index

  // Safety error causes
  assign safety_err = safety_wd_expired_in
                    | safety_comm_err_in
                    | window_exceed_in;

  // Address range check
  assign addr_ok = (addr_switch_in >= `ADDR_MIN) && (addr_switch_in <= `ADDR_MAX);

  // Lamp causes
  assign steady_cond = (addr_switch_in == 8'h00)
                     | telegram_bad_in
                     | reconf_reconnect_in;
  assign blink_cond  = link_absent_in | addr_mismatch_in | param_crc_bad_in
                     | fail_safe_q;

  // Priority resolution
  always_comb
  begin
    if (steady_cond)
      lamp_mode = LAMP_STEADY;
    else if (blink_cond)
      lamp_mode = LAMP_BLINK;
    else
      lamp_mode = LAMP_DARK;
  end

  // Fail-safe latch, cleared only by power-on reset
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      fail_safe_q <= 1'b0;
    else if (safety_err)
      fail_safe_q <= 1'b1;
  end

  // 1 Hz blink generator
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      blink_cnt_q <= 26'h0000000;
      blink_ph_q  <= 1'b0;
    end
    else if (blink_cnt_q == 26'(BLINK_HALF - 1))
    begin
      blink_cnt_q <= 26'h0000000;
      blink_ph_q  <= ~blink_ph_q;
    end
    else
      blink_cnt_q <= blink_cnt_q + 26'h0000001;
  end

  // Registered outputs for lamp and data
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      red_lamp_out     <= 1'b0;
      fail_safe_out    <= 1'b0;
      addr_valid_out   <= 1'b0;
      process_data_out <= 32'h00000000;
    end
    else
    begin
      red_lamp_out     <= (lamp_mode == LAMP_STEADY)
                        | ((lamp_mode == LAMP_BLINK) & blink_ph_q);
      fail_safe_out    <= fail_safe_q | safety_err;
      addr_valid_out   <= addr_ok;
      // Substitute data as soon as a safety error appears
      process_data_out <= (fail_safe_q | safety_err) ? subst_data_in : live_data_in;
    end
  end

  // Frame byte selection
  always_comb
  begin
    case (rd_idx_q)
      8'h00:   frame_byte = station_stat1_in;
      8'h01:   frame_byte = station_stat2_in;
      8'h02:   frame_byte = station_stat3_in;
      8'h03:   frame_byte = master_addr_in;
      8'h04:   frame_byte = MAKER_ID[15:8];
      8'h05:   frame_byte = MAKER_ID[7:0];
      8'h06:   frame_byte = `DIAG_EXT_LEN;
      8'h07:   frame_byte = `EXT_STATUS_TYPE;
      8'h08:   frame_byte = slot_no_in;
      8'h09:   frame_byte = `EXT_STATUS_ID;
      8'h0a:   frame_byte = param_crc_bad_in ? `MOD_STATUS_CRC : `MOD_STATUS_OK;
      default: frame_byte = 8'h00;              // Service bytes
    endcase
  end

  // Readout sequencer, one byte per cycle
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      rd_state_q     <= RD_IDLE;
      rd_idx_q       <= 8'h00;
      diag_byte_out  <= 8'h00;
      diag_valid_out <= 1'b0;
      diag_last_out  <= 1'b0;
    end
    else
    begin
      case (rd_state_q)
        RD_IDLE:
        begin
          diag_valid_out <= 1'b0;
          diag_last_out  <= 1'b0;
          rd_idx_q       <= 8'h00;
          if (diag_req_in)
            rd_state_q <= RD_SEND;
        end
        RD_SEND:
        begin
          diag_byte_out  <= frame_byte;
          diag_valid_out <= 1'b1;
          rd_idx_q       <= rd_idx_q + 8'h01;
          diag_last_out  <= (rd_idx_q == `DIAG_FRAME_LEN - 8'h01);
          if (rd_idx_q == `DIAG_FRAME_LEN - 8'h01)
            rd_state_q <= RD_LAST;
        end
        RD_LAST:
        begin
          diag_valid_out <= 1'b0;
          diag_last_out  <= 1'b0;
          rd_state_q     <= RD_IDLE;
        end
        default:
          rd_state_q <= RD_IDLE;
      endcase
    end
  end

  // Assertions
  sequence s_safety_err;
    safety_err;
  endsequence
  sequence s_failsafe_held;
    fail_safe_out [*8];
  endsequence
  // An idle sequencer that sees a request
  sequence s_frame_start;
    rd_state_q == RD_IDLE && diag_req_in;
  endsequence

  AST_FAILSAFE_ENTER: assert property (@(posedge clk_in) disable iff (reset_in)
    s_safety_err |=> fail_safe_out && process_data_out == $past(subst_data_in))
    else $error("Fail-safe not entered with substitute data");
  AST_FAILSAFE_LATCH: assert property (@(posedge clk_in) disable iff (reset_in)
    fail_safe_q |=> s_failsafe_held)
    else $error("Fail-safe state released without power cycle");
  AST_WD_ERR: assert property (@(posedge clk_in) disable iff (reset_in)
    safety_wd_expired_in |=> fail_safe_q)
    else $error("Watchdog expiry did not latch fail-safe");
  AST_WINDOW_ERR: assert property (@(posedge clk_in) disable iff (reset_in)
    window_exceed_in |=> fail_safe_q)
    else $error("Window overrun did not latch fail-safe");
  AST_ADDR_ZERO: assert property (@(posedge clk_in) disable iff (reset_in)
    addr_switch_in == 8'h00 |=> red_lamp_out && !addr_valid_out)
    else $error("Address zero not lit steady");
  AST_TELEGRAM: assert property (@(posedge clk_in) disable iff (reset_in)
    telegram_bad_in |=> red_lamp_out)
    else $error("Bad telegram not lit steady");
  AST_RECONF: assert property (@(posedge clk_in) disable iff (reset_in)
    reconf_reconnect_in |=> red_lamp_out)
    else $error("Reconfigured reconnect not lit steady");
  AST_DARK: assert property (@(posedge clk_in) disable iff (reset_in)
    !steady_cond && !blink_cond |=> !red_lamp_out)
    else $error("Red lamp lit without error");
  AST_HEADER: assert property (@(posedge clk_in) disable iff (reset_in)
    rd_state_q == RD_SEND && rd_idx_q == 8'h06 |=> diag_byte_out == `DIAG_EXT_LEN)
    else $error("Extended length byte wrong");
  AST_MAKER_HI: assert property (@(posedge clk_in) disable iff (reset_in)
    rd_state_q == RD_SEND && rd_idx_q == 8'h04 |=> diag_byte_out == MAKER_ID[15:8]
    ##1 diag_byte_out == MAKER_ID[7:0])
    else $error("Maker identifier bytes wrong");
  AST_FRAME_LEN: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(diag_valid_out) |-> diag_valid_out [*8] ##[7:7] diag_last_out)
    else $error("Frame length wrong");
  AST_MOD_STATUS: assert property (@(posedge clk_in) disable iff (reset_in)
    rd_state_q == RD_SEND && rd_idx_q == 8'h0a |=>
    diag_byte_out == ($past(param_crc_bad_in) ? `MOD_STATUS_CRC : `MOD_STATUS_OK))
    else $error("Module status byte wrong");

  // Lamp and data behaviour
  AST_STEADY_WINS: assert property (@(posedge clk_in) disable iff (reset_in)
    steady_cond |=> red_lamp_out)
    else $error("Steady cause did not light the lamp");
  AST_BLINK_RATE: assert property (@(posedge clk_in) disable iff (reset_in)
    blink_cnt_q == 26'(BLINK_HALF - 1) |=> blink_ph_q != $past(blink_ph_q))
    else $error("Blink phase did not toggle at half period");
  AST_FAILSAFE_LAMP: assert property (@(posedge clk_in) disable iff (reset_in)
    fail_safe_q && !steady_cond |=> red_lamp_out == $past(blink_ph_q))
    else $error("Fail-safe lamp not blinking");
  AST_SUBST_HOLD: assert property (@(posedge clk_in) disable iff (reset_in)
    fail_safe_q |=> process_data_out == $past(subst_data_in))
    else $error("Live data leaked in fail-safe state");
  AST_LIVE_DATA: assert property (@(posedge clk_in) disable iff (reset_in)
    !fail_safe_q && !safety_err |=> process_data_out == $past(live_data_in))
    else $error("Live data not passed without error");

  // Frame readout behaviour
  AST_FRAME_START: assert property (@(posedge clk_in) disable iff (reset_in)
    s_frame_start |=> rd_state_q == RD_SEND ##1 diag_valid_out
    && diag_byte_out == $past(station_stat1_in))
    else $error("Frame readout did not start");
  AST_MASTER_ADDR: assert property (@(posedge clk_in) disable iff (reset_in)
    rd_state_q == RD_SEND && rd_idx_q == 8'h03 |=> diag_byte_out == $past(master_addr_in))
    else $error("Master address byte wrong");
  AST_STATUS_BLOCK: assert property (@(posedge clk_in) disable iff (reset_in)
    rd_state_q == RD_SEND && rd_idx_q == 8'h07 |=> diag_byte_out == `EXT_STATUS_TYPE
    ##1 diag_byte_out == $past(slot_no_in) ##1 diag_byte_out == `EXT_STATUS_ID)
    else $error("Extended status block wrong");
  AST_READOUT_RUNS: assert property (@(posedge clk_in) disable iff (reset_in)
    rd_state_q == RD_SEND && rd_idx_q != `DIAG_FRAME_LEN - 8'h01
    |=> rd_state_q == RD_SEND && diag_valid_out)
    else $error("Readout broke off before the last byte");
  AST_FRAME_END: assert property (@(posedge clk_in) disable iff (reset_in)
    diag_last_out |=> !diag_valid_out && rd_state_q == RD_IDLE)
    else $error("Frame did not end after the last byte");

endmodule : fault_diag_report

// ### testbench/diag_master_model.sv
// Behavioural bus master that polls the slave diagnosis frame
`timescale 1ns/1ps
module diag_master_model
(
  input  wire logic       clk_in,         // Device clock
  input  wire logic       reset_in,       // Sync reset, active high
  input  wire logic       poll_in,        // Host asks for a slave diagnosis
  input  wire logic [7:0] diag_byte_in,   // Frame byte from the slave
  input  wire logic       diag_valid_in,  // Frame byte valid
  input  wire logic       diag_last_in,   // Last frame byte
  output logic            diag_req_out,   // Request toward the slave
  output logic            done_out,       // Whole frame captured
  output logic            no_answer_out,  // Master-made report: slave silent
  output logic [7:0]      frame_out [15]  // Captured frame bytes
);
  logic [3:0] wait_q;  // Cycles since request without an answer
  logic [3:0] idx_q;   // Next byte slot

  // Request launched off the falling edge, as wide as poll_in
  always @(negedge clk_in)
    diag_req_out <= poll_in && !reset_in;

  // Capture bytes in order and watch for a silent slave
  always @(posedge clk_in)
  begin
    if (reset_in || diag_req_out)
    begin
      idx_q         <= 4'h0;
      done_out      <= 1'b0;
      no_answer_out <= 1'b0;
      wait_q        <= {3'h0, diag_req_out};
    end
    else if (diag_valid_in)
    begin
      frame_out[idx_q] <= diag_byte_in;
      idx_q            <= idx_q + 4'h1;
      done_out         <= diag_last_in;
      wait_q           <= 4'h0;
    end
    else if (wait_q != 4'h0 && wait_q != 4'hf)
    begin
      wait_q        <= wait_q + 4'h1;
      no_answer_out <= wait_q > 4'h8;
    end
  end
endmodule : diag_master_model

// ### testbench/tb_top.sv
// Self-checking bench for the fault lamp and diagnosis frame block
`timescale 1ns/1ps
module tb_top;
  import fault_diag_pkg::*;
  localparam logic [15:0] MAKER = 16'h3c96; // Arbitrary identifier value
  logic        clk_in, reset_in, poll, req, done, no_ans;
  logic [7:0]  causes; // link, addr, crc, wd, comm, window, telegram, reconf
  logic [7:0]  sw, st1, st2, st3, mst, slot, dbyte;
  logic [31:0] live, subst, pdata;
  logic        lamp, fsafe, avalid, dvalid, dlast;
  logic [7:0]  frame [15];
  int          err_total, n_checks;

  fault_diag_report #(.BLINK_HALF(4), .MAKER_ID(MAKER)) fault_diag_report_inst (
    .clk_in(clk_in), .reset_in(reset_in), .link_absent_in(causes[0]),
    .addr_mismatch_in(causes[1]), .param_crc_bad_in(causes[2]),
    .safety_wd_expired_in(causes[3]), .safety_comm_err_in(causes[4]),
    .window_exceed_in(causes[5]), .telegram_bad_in(causes[6]),
    .reconf_reconnect_in(causes[7]), .addr_switch_in(sw), .live_data_in(live),
    .subst_data_in(subst), .station_stat1_in(st1), .station_stat2_in(st2),
    .station_stat3_in(st3), .master_addr_in(mst), .slot_no_in(slot),
    .diag_req_in(req), .red_lamp_out(lamp), .fail_safe_out(fsafe),
    .addr_valid_out(avalid), .process_data_out(pdata), .diag_byte_out(dbyte),
    .diag_valid_out(dvalid), .diag_last_out(dlast));

  diag_master_model diag_master_model_inst (
    .clk_in(clk_in), .reset_in(reset_in), .poll_in(poll), .diag_byte_in(dbyte),
    .diag_valid_in(dvalid), .diag_last_in(dlast), .diag_req_out(req),
    .done_out(done), .no_answer_out(no_ans), .frame_out(frame));

  // 50 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Count a comparison and report a mismatch
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Print counts and verdict, then stop
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // Hold reset for ten cycles
  task automatic do_reset;
    reset_in <= 1'b1;
    repeat (10) @(negedge clk_in);
    reset_in <= 1'b0;
    @(negedge clk_in);
  endtask : do_reset

  // Count lit cycles of the red lamp
  task automatic count_lit(input int n, output int lit);
    lit = 0;
    repeat (n)
    begin
      @(negedge clk_in);
      lit += lamp;
    end
  endtask : count_lit

  // Switch values on both sides of the valid range
  task automatic t_addr;
    logic [7:0] vals [4];
    int lit;
    vals = '{8'h00, 8'h01, 8'h63, 8'h64};
    for (int i = 0; i < 4; i++)
    begin
      sw <= vals[i];
      repeat (2) @(negedge clk_in);
      check("address valid", vals[i] != 8'h00 && vals[i] < 8'h64, avalid);
    end
    sw <= 8'h00;
    repeat (2) @(negedge clk_in);
    count_lit(10, lit);
    check("steady lamp on zero address", 10, lit);
    sw <= 8'h05;
  endtask : t_addr

  // Blink causes, then steady causes on top of a blink cause
  task automatic t_lamp;
    int lit;
    for (int i = 0; i < 3; i++)
    begin
      causes <= 8'h01 << i;
      repeat (2) @(negedge clk_in);
      count_lit(16, lit);
      check("blink lit cycles", 8, lit);
    end
    for (int j = 6; j < 8; j++)
    begin
      causes <= 8'h01 | (8'h01 << j); // Link cause plus telegram cause, then reconnect cause
      repeat (2) @(negedge clk_in);
      count_lit(16, lit);
      check("steady over blink", 16, lit);
    end
    causes <= 8'h00;
    repeat (2) @(negedge clk_in);
    check("lamp dark", 0, lamp);
  endtask : t_lamp

  // Poll one frame and compare every byte
  task automatic t_diag(input logic crc);
    logic [7:0] exp [15];
    int n;
    causes <= {5'h00, crc, 2'b00};
    poll <= 1'b1;
    @(negedge clk_in);
    poll <= 1'b0;
    // Let the model drop the done flag of the previous frame first
    @(negedge clk_in);
    n = 0;
    while (!done && n < 40)
    begin
      @(negedge clk_in);
      n++;
    end
    check("frame done in time", 1, done);
    if (n >= 40)
      final_report();
    exp = '{st1, st2, st3, mst, MAKER[15:8], MAKER[7:0], 8'h09, 8'h82, slot,
            8'h00, crc ? 8'h03 : 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 15; i++)
      check("frame byte", exp[i], frame[i]);
    check("no master-made report", 0, no_ans);
    causes <= 8'h00;
  endtask : t_diag

  // Each safety error latches fail-safe until reset
  task automatic t_failsafe;
    int lit;
    for (int k = 3; k < 6; k++)
    begin
      do_reset();
      check("fail-safe clear", 0, fsafe);
      causes <= 8'h01 << k;
      @(negedge clk_in);
      causes <= 8'h00;
      @(negedge clk_in);
      check("fail-safe set", 1, fsafe);
      live <= live + 32'h1;
      @(negedge clk_in);
      check("substitute data", subst, pdata);
      t_diag(1'b0);
      count_lit(16, lit);
      check("fail-safe blink", 8, lit);
      check("fail-safe held", 1, fsafe);
    end
    do_reset();
    check("fail-safe after power cycle", 0, fsafe);
  endtask : t_failsafe

  // Main sequence
  initial
  begin
    causes = 8'h00;
    reset_in = 1'b1;
    poll = 1'b0;
    sw = 8'h05;
    live = 32'h1234_5678;
    subst = 32'h0bad_0bad;
    st1 = 8'h08;
    st2 = 8'h04;
    st3 = 8'h80;
    mst = 8'h02;
    slot = 8'h01;
    err_total = 0;
    n_checks = 0;
    do_reset();
    check("lamp after reset", 0, lamp);
    check("live data", live, pdata);
    t_addr();
    t_lamp();
    t_diag(1'b0);
    t_diag(1'b1);
    t_failsafe();
    final_report();
  end
endmodule : tb_top
